/* File: verilog/serial_multi_io_flash_port.v */
// serial multi-lane flash port: pin protocol, read stream, program and erase engine
`include "flash_port_defines.vh"
module serial_multi_io_flash_port (
    // system
    input wire clk,
    input wire rst_b,
    // serial pins
    input wire sclk,
    input wire csB,
    input wire dataLane0In,
    input wire dataLane1In,
    input wire writeProtectLane2In,
    input wire pauseLane3In,
    output wire dataLane0Out,
    output wire dataLane1Out,
    output wire writeProtectLane2Out,
    output wire pauseLane3Out,
    output wire dataLane0OeB,
    output wire dataLane1OeB,
    output wire writeProtectLane2OeB,
    output wire pauseLane3OeB,
    // array port
    output reg [20:0] memAddr_r,
    output reg memRd_r,
    input wire [7:0] memRdData,
    output reg memPgm_r,
    output reg [7:0] memPgmData_r,
    output reg memErase_r,
    output reg [1:0] memEraseSize_r
);

localparam S_CMD = 6'b000001;
localparam S_ADR = 6'b000010;
localparam S_DUM = 6'b000100;
localparam S_DIN = 6'b001000;
localparam S_OUT = 6'b010000;
localparam S_IGN = 6'b100000;
localparam E_IDLE = 6'b000001;
localparam E_SCAN = 6'b000010;
localparam E_PGM = 6'b000100;
localparam E_ERS = 6'b001000;
localparam E_RD = 6'b010000;
localparam E_CHK = 6'b100000;

// ==========================================
// pin synchronisers
reg [5:0] syA_r;
reg [5:0] syB_r;
reg [1:0] prv_r;
reg qe_r;
always @(posedge clk) begin
    if (!rst_b) begin
        syA_r <= 6'h3E;
        syB_r <= 6'h3E;
        prv_r <= 2'h2;
    end else begin
        syA_r <= {pauseLane3In, writeProtectLane2In, dataLane1In, dataLane0In, csB, sclk};
        syB_r <= syA_r;
        prv_r <= syB_r[1:0];
    end
end
wire [3:0] ln = syB_r[5:2];
wire selB = syB_r[1];
// pause pin only counts when it is not a data lane
wire holdAct = !qe_r && !ln[3] && !selB;
// edges of either idle level, so mode 0 and mode 3 look alike
wire rise = syB_r[0] && !prv_r[0] && !selB && !holdAct;
wire fall = !syB_r[0] && prv_r[0] && !selB && !holdAct;
wire csFall = !selB && prv_r[1];
wire csRise = selB && !prv_r[1];

// ==========================================
// shared state
reg [5:0] st_r;
reg [7:0] cmd_r;
reg [23:0] sh_r;
reg [4:0] cnt_r;
reg [4:0] len_r;
reg [3:0] dum_r;
reg [2:0] w_r;
reg [23:0] adr_r;
reg [20:0] rdA_r;
reg [7:0] ptr_r;
reg [7:0] din_r;
reg got_r;
reg bad_r;
reg [1:0] idx_r;
reg wel_r;
reg srwd_r;
reg susp_r;
reg wrapOff_r;
reg [3:0] bp_r;
reg [1:0] wsel_r;
reg stP_r;
reg stE_r;
reg [1:0] eSz_r;
reg [255:0] pMask_r;
reg [7:0] pBuf_r [0:255];
reg [5:0] eSt_r;
reg [20:0] eA_r;
reg pend_r;
reg ack_r;
reg [7:0] fMem_r [0:1];
reg fWp_r;
reg fRp_r;
reg [1:0] fCnt_r;

wire eOn = eSt_r != E_IDLE;
wire busy = eOn && !susp_r;
wire [7:0] stat = {srwd_r, qe_r, bp_r, wel_r, busy};
wire pinProt = srwd_r && !ln[2] && !qe_r;

function isProt;
    input [3:0] lv;
    input [4:0] blk;
    reg [5:0] b6;
    begin
        b6 = {1'b0, blk};
        if (lv == 4'd0)
            isProt = 1'b0;
        else if (lv <= `PL_TOP_MAX)
            isProt = b6 >= (`BLK_COUNT - (6'd1 << (lv - 4'd1)));
        else if (lv >= `PL_BOT_MIN && lv <= `PL_BOT_MAX)
            isProt = b6 < (`BLK_COUNT - (6'd1 << (`PL_BOT_MAX - lv)));
        else
            isProt = 1'b1;
    end
endfunction

reg [23:0] shIn;
always @* begin
    case (w_r)
        `LANES2: shIn = {sh_r[21:0], ln[1:0]};
        `LANES4: shIn = {sh_r[19:0], ln};
        default: shIn = {sh_r[22:0], ln[0]};
    endcase
end
wire [7:0] nb = shIn[7:0];
wire isRd = cmd_r == `OP_READ || cmd_r == `OP_FAST || cmd_r == `OP_READ2 || cmd_r == `OP_READ4;
wire isErs = cmd_r == `OP_SE || cmd_r == `OP_BE32 || cmd_r == `OP_BE64;
wire endOk = st_r == S_IGN && !bad_r;
wire dinOk = st_r == S_DIN && cnt_r == 5'd0 && got_r;
wire blkProt = isProt(bp_r, adr_r[20:16]);
wire pbWr = rise && st_r == S_DIN && cnt_r == 5'd7 && cmd_r == `OP_PP;

// ==========================================
// read stream fill into the two-entry buffer
reg [5:0] wm;
always @* begin
    case (wsel_r)
        2'd0: wm = 6'h07;
        2'd1: wm = 6'h0F;
        2'd2: wm = 6'h1F;
        default: wm = 6'h3F;
    endcase
end
wire [20:0] wm21 = {15'h0000, wm};
wire [20:0] rdInc = rdA_r + 21'h00_0001;
wire [20:0] rdNext = wrapOff_r ? rdInc : ((rdA_r & ~wm21) | (rdInc & wm21));
wire fillOn = (st_r == S_DUM || st_r == S_OUT) && !selB;
wire fRdy = fCnt_r != 2'd2;
// fetch stalls on a full buffer, so a slow host loses nothing
wire fetch = fillOn && isRd && !pend_r && fRdy;
wire gen = fillOn && !isRd && fRdy;
wire eRdReq = eSt_r == E_RD && !susp_r;
reg [7:0] genB;
always @* begin
    case (cmd_r)
        `OP_RDSR: genB = stat;
        `OP_RDID: genB = (idx_r == 2'd0) ? `ID_MAKER : ((idx_r == 2'd1) ? `ID_TYPE : `ID_CAP);
        `OP_MKDEV: genB = (idx_r[0] ^ adr_r[0]) ? `ID_SIG : `ID_MAKER;
        default: genB = `ID_SIG;
    endcase
end
wire push = gen || (ack_r && pend_r && fillOn);
wire [7:0] pushD = gen ? genB : memRdData;

// ==========================================
// command protocol
always @(posedge clk) begin
    if (!rst_b) begin
        st_r <= S_IGN;
        cmd_r <= `OP_NONE;
        sh_r <= 24'h00_0000;
        cnt_r <= 5'd0;
        len_r <= `ADR_CLK1;
        dum_r <= 4'd0;
        w_r <= `LANES1;
        adr_r <= 24'h00_0000;
        rdA_r <= 21'h00_0000;
        ptr_r <= 8'h00;
        din_r <= 8'h00;
        got_r <= 1'b0;
        bad_r <= 1'b0;
        idx_r <= 2'd0;
        wel_r <= 1'b0;
        qe_r <= 1'b0;
        srwd_r <= 1'b0;
        susp_r <= 1'b0;
        wrapOff_r <= 1'b1;
        bp_r <= 4'h0;
        wsel_r <= 2'd0;
        stP_r <= 1'b0;
        stE_r <= 1'b0;
        eSz_r <= `SZ_4K;
        pMask_r <= 256'h0;
    end else begin
        stP_r <= 1'b0;
        stE_r <= 1'b0;
        if (gen) begin
            idx_r <= (idx_r == 2'd2) ? 2'd0 : idx_r + 2'd1;
        end
        if (fetch) begin
            rdA_r <= rdNext;
        end
        if (csFall) begin
            st_r <= S_CMD;
            cnt_r <= 5'd0;
            w_r <= `LANES1;
            bad_r <= 1'b0;
            got_r <= 1'b0;
            idx_r <= 2'd0;
        end else if (csRise) begin
            st_r <= S_IGN;
            cmd_r <= `OP_NONE;
            case (cmd_r)
                `OP_WRITE_UNLOCK_CMD: if (endOk) wel_r <= 1'b1;
                `OP_WRDI: if (endOk) wel_r <= 1'b0;
                `OP_WRSR: if (dinOk && wel_r && !pinProt && !eOn) begin
                    srwd_r <= din_r[`SR_SRWD];
                    qe_r <= din_r[`SR_QE];
                    bp_r <= din_r[`SR_BP_HI:`SR_BP_LO];
                    wel_r <= 1'b0;
                end
                `OP_WRAP: if (dinOk) begin
                    wrapOff_r <= din_r[`WRAP_OFF_BIT];
                    wsel_r <= din_r[1:0];
                end
                `OP_PP: if (dinOk && wel_r && !eOn && !blkProt) begin
                    stP_r <= 1'b1;
                    wel_r <= 1'b0;
                end
                `OP_CE: if (endOk && wel_r && !eOn && bp_r == 4'h0) begin
                    stE_r <= 1'b1;
                    eSz_r <= `SZ_CHIP;
                    wel_r <= 1'b0;
                end
                `OP_SUSP: if (endOk && eOn) susp_r <= 1'b1;
                `OP_RSM: if (endOk) susp_r <= 1'b0;
                default: if (isErs && endOk && wel_r && !eOn && !blkProt) begin
                    stE_r <= 1'b1;
                    eSz_r <= (cmd_r == `OP_SE) ? `SZ_4K : ((cmd_r == `OP_BE32) ? `SZ_32K : `SZ_64K);
                    wel_r <= 1'b0;
                end
            endcase
        end else if (rise) begin
            case (st_r)
                S_CMD: begin
                    sh_r <= shIn;
                    cnt_r <= cnt_r + 5'd1;
                    if (cnt_r == 5'd7) begin
                        cnt_r <= 5'd0;
                        cmd_r <= nb;
                        len_r <= `ADR_CLK1;
                        dum_r <= 4'd0;
                        if (busy && nb != `OP_RDSR && nb != `OP_SUSP && nb != `OP_RSM) begin
                            cmd_r <= `OP_NONE;
                            st_r <= S_IGN;
                        end else begin
                            case (nb)
                                `OP_READ, `OP_SIG, `OP_MKDEV, `OP_SE, `OP_BE32, `OP_BE64: st_r <= S_ADR;
                                `OP_FAST: begin
                                    st_r <= S_ADR;
                                    dum_r <= `DUM_FAST;
                                end
                                `OP_READ2: begin
                                    st_r <= S_ADR;
                                    w_r <= `LANES2;
                                    len_r <= `ADR_CLK2;
                                    dum_r <= `DUM_DUAL;
                                end
                                `OP_READ4: begin
                                    st_r <= qe_r ? S_ADR : S_IGN;
                                    cmd_r <= qe_r ? nb : `OP_NONE;
                                    w_r <= `LANES4;
                                    len_r <= `ADR_CLK4;
                                    dum_r <= `DUM_QUAD;
                                end
                                `OP_PP: begin
                                    st_r <= eOn ? S_IGN : S_ADR;
                                    cmd_r <= eOn ? `OP_NONE : nb;
                                    if (!eOn) pMask_r <= 256'h0;
                                end
                                `OP_RDSR, `OP_RDID: st_r <= S_OUT;
                                `OP_WRSR, `OP_WRAP: st_r <= S_DIN;
                                default: st_r <= S_IGN;
                            endcase
                        end
                    end
                end
                S_ADR: begin
                    sh_r <= shIn;
                    cnt_r <= cnt_r + 5'd1;
                    if (cnt_r == len_r - 5'd1) begin
                        cnt_r <= 5'd0;
                        adr_r <= shIn;
                        rdA_r <= shIn[20:0];
                        ptr_r <= shIn[7:0];
                        if (dum_r != 4'd0)
                            st_r <= S_DUM;
                        else if (cmd_r == `OP_PP)
                            st_r <= S_DIN;
                        else if (isErs)
                            st_r <= S_IGN;
                        else
                            st_r <= S_OUT;
                    end
                end
                S_DUM: begin
                    cnt_r <= cnt_r + 5'd1;
                    if (cnt_r == {1'b0, dum_r} - 5'd1) begin
                        cnt_r <= 5'd0;
                        st_r <= S_OUT;
                    end
                end
                S_DIN: begin
                    sh_r <= shIn;
                    cnt_r <= cnt_r + 5'd1;
                    if (cnt_r == 5'd7) begin
                        cnt_r <= 5'd0;
                        got_r <= 1'b1;
                        din_r <= nb;
                        if (cmd_r == `OP_PP) begin
                            pMask_r[ptr_r] <= 1'b1;
                            ptr_r <= ptr_r + 8'h01;
                        end
                    end
                end
                S_IGN: bad_r <= 1'b1;
                default: bad_r <= bad_r;
            endcase
        end
    end
end

// page buffer, no reset needed
always @(posedge clk) begin
    if (pbWr) begin
        pBuf_r[ptr_r] <= nb;
    end
end

// ==========================================
// two-entry output buffer
wire pushOk = push && fRdy;
reg [7:0] oSh_r;
reg [3:0] left_r;
wire pop = fall && st_r == S_OUT && left_r == 4'd0 && fCnt_r != 2'd0;
always @(posedge clk) begin
    if (!rst_b || csFall) begin
        fWp_r <= 1'b0;
        fRp_r <= 1'b0;
        fCnt_r <= 2'd0;
    end else begin
        if (pushOk) begin
            fMem_r[fWp_r] <= pushD;
            fWp_r <= ~fWp_r;
        end
        if (pop) begin
            fRp_r <= ~fRp_r;
        end
        fCnt_r <= fCnt_r + {1'b0, pushOk} - {1'b0, pop};
    end
end

// ==========================================
// lane drivers
reg drv_r;
reg [3:0] oL_r;
reg [3:0] oeB_r;
// an empty buffer repeats stale bits; the fill rate keeps it ahead
wire [7:0] word = (left_r == 4'd0) ? fMem_r[fRp_r] : oSh_r;
wire [3:0] cpb = (w_r == `LANES4) ? 4'd2 : ((w_r == `LANES2) ? 4'd4 : 4'd8);
wire [3:0] used = (w_r == `LANES4) ? 4'hF : ((w_r == `LANES2) ? 4'h3 : 4'h2);
wire drvNow = drv_r && !selB && !holdAct && st_r == S_OUT;
always @(posedge clk) begin
    if (!rst_b) begin
        drv_r <= 1'b0;
        left_r <= 4'd0;
        oSh_r <= 8'h00;
        oL_r <= 4'h0;
    end else if (selB) begin
        drv_r <= 1'b0;
        left_r <= 4'd0;
    end else if (fall && st_r == S_OUT) begin
        drv_r <= 1'b1;
        left_r <= ((left_r == 4'd0) ? cpb : left_r) - 4'd1;
        case (w_r)
            `LANES4: begin
                oL_r <= word[7:4];
                oSh_r <= {word[3:0], 4'h0};
            end
            `LANES2: begin
                oL_r <= {2'b00, word[7:6]};
                oSh_r <= {word[5:0], 2'b00};
            end
            default: begin
                oL_r <= {2'b00, word[7], 1'b0};
                oSh_r <= {word[6:0], 1'b0};
            end
        endcase
    end
end
genvar gi;
generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_oe
        always @(posedge clk) begin
            if (!rst_b)
                oeB_r[gi] <= 1'b1;
            else
                oeB_r[gi] <= !(drvNow && used[gi]);
        end
    end
endgenerate
assign dataLane0Out = oL_r[0];
assign dataLane1Out = oL_r[1];
assign writeProtectLane2Out = oL_r[2];
assign pauseLane3Out = oL_r[3];
assign dataLane0OeB = oeB_r[0];
assign dataLane1OeB = oeB_r[1];
assign writeProtectLane2OeB = oeB_r[2];
assign pauseLane3OeB = oeB_r[3];

// ==========================================
// array port reads
always @(posedge clk) begin
    if (!rst_b) begin
        memRd_r <= 1'b0;
        ack_r <= 1'b0;
        pend_r <= 1'b0;
        memAddr_r <= 21'h00_0000;
    end else begin
        memRd_r <= fetch || eRdReq;
        ack_r <= memRd_r;
        memAddr_r <= fetch ? rdA_r : eA_r;
        if (fetch)
            pend_r <= 1'b1;
        else if (ack_r)
            pend_r <= 1'b0;
    end
end

// ==========================================
// program and erase engine
reg [20:0] eBase_r;
reg [20:0] eEnd_r;
reg eErs_r;
reg [1:0] eTry_r;
reg [3:0] eW_r;
reg [20:0] eMsk;
always @* begin
    case (eSz_r)
        `SZ_4K: eMsk = `MSK_4K;
        `SZ_32K: eMsk = `MSK_32K;
        `SZ_64K: eMsk = `MSK_64K;
        default: eMsk = `MSK_CHIP;
    endcase
end
// program only pulls bits low, so check just the zeros asked for
wire eOk = eErs_r ? (memRdData == `ERASED) : ((memRdData & ~pBuf_r[eA_r[7:0]]) == 8'h00);
wire eLast = eErs_r ? (eA_r == eEnd_r) : (&eA_r[7:0]);
always @(posedge clk) begin
    if (!rst_b) begin
        eSt_r <= E_IDLE;
        eA_r <= 21'h00_0000;
        eBase_r <= 21'h00_0000;
        eEnd_r <= 21'h00_0000;
        eErs_r <= 1'b0;
        eTry_r <= 2'd0;
        eW_r <= 4'd0;
        memPgm_r <= 1'b0;
        memPgmData_r <= 8'h00;
        memErase_r <= 1'b0;
        memEraseSize_r <= `SZ_4K;
    end else begin
        memPgm_r <= 1'b0;
        memErase_r <= 1'b0;
        case (eSt_r)
            E_IDLE: begin
                eTry_r <= 2'd0;
                eW_r <= 4'd0;
                if (stP_r) begin
                    eErs_r <= 1'b0;
                    eA_r <= {adr_r[20:8], 8'h00};
                    eSt_r <= E_SCAN;
                end else if (stE_r) begin
                    eErs_r <= 1'b1;
                    eA_r <= adr_r[20:0] & ~eMsk;
                    eBase_r <= adr_r[20:0] & ~eMsk;
                    eEnd_r <= adr_r[20:0] | eMsk;
                    memEraseSize_r <= eSz_r;
                    eSt_r <= E_ERS;
                end
            end
            E_SCAN: if (!susp_r) begin
                if (pMask_r[eA_r[7:0]]) begin
                    eW_r <= 4'd0;
                    eSt_r <= E_PGM;
                end else if (&eA_r[7:0])
                    eSt_r <= E_IDLE;
                else
                    eA_r <= eA_r + 21'h00_0001;
            end
            E_PGM: if (!susp_r) begin
                eW_r <= eW_r + 4'd1;
                if (eW_r == 4'd0) begin
                    memPgm_r <= 1'b1;
                    memPgmData_r <= pBuf_r[eA_r[7:0]];
                end
                if (eW_r == `STEP_CYC)
                    eSt_r <= E_RD;
            end
            E_ERS: if (!susp_r) begin
                eW_r <= eW_r + 4'd1;
                if (eW_r == 4'd0)
                    memErase_r <= 1'b1;
                if (eW_r == `STEP_CYC) begin
                    eA_r <= eBase_r;
                    eSt_r <= E_RD;
                end
            end
            E_RD: if (!susp_r) eSt_r <= E_CHK;
            E_CHK: if (ack_r) begin
                if (eOk || eTry_r == `TRY_MAX) begin
                    if (eLast)
                        eSt_r <= E_IDLE;
                    else begin
                        eA_r <= eA_r + 21'h00_0001;
                        eSt_r <= eErs_r ? E_RD : E_SCAN;
                        if (!eErs_r) eTry_r <= 2'd0;
                    end
                end else begin
                    eTry_r <= eTry_r + 2'd1;
                    eW_r <= 4'd0;
                    eSt_r <= eErs_r ? E_ERS : E_PGM;
                end
            end
            default: eSt_r <= E_IDLE;
        endcase
    end
end

endmodule // serial_multi_io_flash_port

/* File: verilog/flash_port_defines.vh */
// constants of the serial multi-lane flash port
// Notes on behaviour
// - serial clock mode 0 and mode 3 both work; sample rising, drive falling.
// - single-lane fast read waits 8 dummy clocks after the address.
// - two-lane address and data read waits 4 dummy clocks.
// - four-lane read waits six clocks: two mode clocks, four dummy clocks.
// - wrap burst read wraps within an aligned 8, 16, 32 or 64 bytes.
// - access only while select low; single lane: in on lane 0, out on lane 1.
// - two-lane read: lanes 0 and 1 carry address, dummy and data.
// - four-lane read: protect and pause pins also become lanes 2 and 3.
// - program runs an automatic program and verify loop within a 256-byte page.
// - erase runs automatically with verify on 4K, 32K, 64K or whole array.
// - busy flag in status shows a running program or erase for polling.
// - four-bit protect level marks array blocks refusing program and erase.
// - pause input low, outside four-lane mode, freezes the transaction without deselecting the device.
// - identification: three-byte id, one-byte signature, maker plus device byte.
// - suspend and resume commands pause and continue program or erase.
// - reads stream sequential bytes, address advancing across the whole array while wrap burst is off.
// - program, erase and status write need the write latch set first.
// - whole-array erase only when all protect level bits are zero.
// - pin protection of the status register is off in four-lane mode.
`ifndef FLASH_PORT_DEFINES_VH
`define FLASH_PORT_DEFINES_VH
`define OP_NONE 8'h00
`define OP_READ 8'h03
`define OP_FAST 8'h0B
`define OP_READ2 8'hBB
`define OP_READ4 8'hEB
`define OP_WRITE_UNLOCK_CMD 8'h06
`define OP_WRDI 8'h04
`define OP_RDSR 8'h05
`define OP_WRSR 8'h01
`define OP_RDID 8'h9F
`define OP_SIG 8'hAB
`define OP_MKDEV 8'h90
`define OP_PP 8'h02
`define OP_SE 8'h20
`define OP_BE32 8'h52
`define OP_BE64 8'hD8
`define OP_CE 8'hC7
`define OP_SUSP 8'hB0
`define OP_RSM 8'h30
`define OP_WRAP 8'hC0
`define LANES1 3'd1
`define LANES2 3'd2
`define LANES4 3'd4
`define ADR_CLK1 5'd24
`define ADR_CLK2 5'd12
`define ADR_CLK4 5'd6
`define DUM_FAST 4'd8
`define DUM_DUAL 4'd4
`define DUM_QUAD 4'd6
`define SR_BP_LO 2
`define SR_BP_HI 5
`define SR_QE 6
`define SR_SRWD 7
`define WRAP_OFF_BIT 4
`define SZ_4K 2'd0
`define SZ_32K 2'd1
`define SZ_64K 2'd2
`define SZ_CHIP 2'd3
`define MSK_4K 21'h00_0FFF
`define MSK_32K 21'h00_7FFF
`define MSK_64K 21'h00_FFFF
`define MSK_CHIP 21'h1F_FFFF
`define PL_TOP_MAX 4'd5
`define PL_BOT_MIN 4'd10
`define PL_BOT_MAX 4'd14
`define BLK_COUNT 6'd32
`define STEP_CYC 4'd8
`define TRY_MAX 2'd3
`define ERASED 8'hFF
// identity values are arbitrary
`define ID_MAKER 8'h5A
`define ID_TYPE 8'h21
`define ID_CAP 8'h15
`define ID_SIG 8'h14
`endif

/* File: sim/serial_multi_io_flash_port_asserts.sv */
// assertions on the flash port pins and array port
module serial_multi_io_flash_port_asserts (
    // watched ports
    input wire clk,
    input wire rst_b,
    input wire sclk,
    input wire csB,
    input wire pauseLane3In,
    input wire dataLane1Out,
    input wire dataLane1OeB,
    input wire pauseLane3OeB,
    input wire [20:0] memAddr_r,
    input wire memRd_r,
    input wire memPgm_r,
    input wire memErase_r,
    input wire [1:0] memEraseSize_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ==========
    // pins
    chk_cs_release: assert property (csB [*6] |-> dataLane1OeB)
        else $error("lane 1 driven while deselected");
    chk_drive_fall: assert property ($changed(dataLane1Out) |-> !sclk)
        else $error("lane 1 changed while sclk high");
    chk_drive_selected: assert property ($fell(dataLane1OeB) |-> !sclk && !csB)
        else $error("lane 1 drive began outside a low clock phase");
    chk_pause_release: assert property ((pauseLane3OeB && !pauseLane3In) [*6] |-> dataLane1OeB)
        else $error("lane 1 driven during pause");
    // ==========
    // array
    chk_pgm_single: assert property (memPgm_r |=> !memPgm_r && !memErase_r)
        else $error("program pulse too long");
    chk_pgm_verify: assert property (memPgm_r |-> ##[8:12] memRd_r)
        else $error("no verify read after program");
    chk_erase_verify: assert property (memErase_r |-> !memPgm_r ##1 !memErase_r ##[7:11] memRd_r)
        else $error("no verify read after erase");
    chk_erase_align: assert property (memErase_r && memEraseSize_r != 2'd3 |-> memAddr_r[11:0] == 12'h000)
        else $error("erase base not aligned");
endmodule // serial_multi_io_flash_port_asserts

/* File: sim/flash_array_model.sv */
// array model behind the flash port
module flash_array_model (
    // array port
    input wire clk,
    input wire [20:0] memAddr_r,
    input wire memRd_r,
    output logic [7:0] memRdData,
    input wire memPgm_r,
    input wire [7:0] memPgmData_r,
    input wire memErase_r,
    input wire [1:0] memEraseSize_r
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [int];
    logic [20:0] keep;
    function automatic logic [7:0] rd(int a);
        return mem.exists(a) ? mem[a] : 8'hFF;
    endfunction
    initial memRdData = 8'h00;
    always @(posedge clk) begin
        keep = memEraseSize_r == 2'd3 ? 21'h00_0000 : (memEraseSize_r == 2'd2 ? 21'h1F_0000 : 21'h1F_F000);
        if (memEraseSize_r == 2'd1) keep = 21'h1F_8000;
        // data toggles outside its slot so a late sample is caught
        memRdData <= memRd_r ? rd(memAddr_r) : ~memRdData;
        if (memPgm_r) mem[memAddr_r] = memPgmData_r & rd(memAddr_r);
        if (memErase_r) foreach (mem[k]) if ((k[20:0] & keep) == (memAddr_r & keep)) mem[k] = 8'hFF;
    end
endmodule // flash_array_model

/* File: sim/serial_multi_io_flash_port_tb_top.sv */
// flash port testbench: host tasks, scenarios, verdict
`include "flash_port_defines.vh"
`define CHK(nm, e, s) begin numChecks++; if ((s) !== (e)) begin nFail++; \
    $display("Error %s expected %h seen %h", nm, e, s); end end
module serial_multi_io_flash_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_b = 0, sclk = 0, csB = 1, din = 1, pauseB = 1;
    wire o0, o1, o2, o3, e0, e1, e2, e3, rd, pg, er;
    wire [20:0] adr;
    wire [7:0] rdd, pgd;
    wire [1:0] esz;
    // undriven lane 1 toggles; lane 2 pulled high, lane 3 follows pauseB
    wire l0 = e0 ? din : o0;
    wire l1 = e1 ? clk : o1;
    wire l2 = e2 ? 1'b1 : o2;
    wire l3 = e3 ? pauseB : o3;
    int nFail = 0, numChecks = 0;
    logic [7:0] rx [$];
    serial_multi_io_flash_port i_serial_multi_io_flash_port (.clk(clk), .rst_b(rst_b), .sclk(sclk), .csB(csB),
        .dataLane0In(l0), .dataLane1In(l1), .writeProtectLane2In(l2), .pauseLane3In(l3), .dataLane0Out(o0),
        .dataLane1Out(o1), .writeProtectLane2Out(o2), .pauseLane3Out(o3), .dataLane0OeB(e0), .dataLane1OeB(e1),
        .writeProtectLane2OeB(e2), .pauseLane3OeB(e3), .memAddr_r(adr), .memRd_r(rd), .memRdData(rdd),
        .memPgm_r(pg), .memPgmData_r(pgd), .memErase_r(er), .memEraseSize_r(esz));
    flash_array_model i_flash_array_model (.clk(clk), .memAddr_r(adr), .memRd_r(rd), .memRdData(rdd),
        .memPgm_r(pg), .memPgmData_r(pgd), .memErase_r(er), .memEraseSize_r(esz));
    always #2 clk = ~clk;
    // ==========
    // host
    task automatic half;
        repeat (16) @(negedge clk);
    endtask
    task automatic xfer(input logic [7:0] q [$], input int nr, input bit pz = 0, bit m3 = 0);
        logic [7:0] b;
        rx = {};
        sclk = m3;
        csB = 0;
        half;
        sclk = 0;
        for (int k = 0; k < q.size() + nr; k++) begin
            for (int i = 7; i >= 0; i--) begin
                din = k < q.size() ? q[k][i] : 1'b1;
                half;
                sclk = 1;
                b[i] = l1;
                half;
                sclk = 0;
            end
            if (k >= q.size()) rx.push_back(b);
            if (pz && k == q.size()) begin
                half;
                pauseB = 0;
                half;
                pauseB = 1;
            end
        end
        half;
        csB = 1;
        repeat (8) @(negedge clk);
    endtask
    task automatic waitIdle;
        int n = 0;
        do begin
            xfer({`OP_RDSR}, 3);
            n++;
        end while (rx[2][0] !== 1'b0 && n < 200);
        `CHK("busy", 1'b0, rx[2][0])
    endtask
    // ==========
    // scenarios
    task automatic testLatch;
        xfer({`OP_WRITE_UNLOCK_CMD}, 0);
        xfer({`OP_RDSR}, 3);
        `CHK("latch set", 8'h02, rx[2])
        xfer({`OP_WRDI}, 0);
        xfer({`OP_RDSR}, 3);
        `CHK("latch clear", 8'h00, rx[2])
        xfer({`OP_RDID}, 4, 0, 1);
        `CHK("id", {`ID_MAKER, `ID_TYPE, `ID_CAP, `ID_MAKER}, {rx[0], rx[1], rx[2], rx[3]})
        xfer({`OP_SIG, 8'h00, 8'h00, 8'h00}, 2);
        `CHK("signature", {`ID_SIG, `ID_SIG}, {rx[0], rx[1]})
        $display("id test done");
    endtask
    task automatic testProgram;
        xfer({`OP_WRITE_UNLOCK_CMD}, 0);
        xfer({`OP_PP, 8'h00, 8'h01, 8'hFE, 8'hA5, 8'h3C, 8'h5A}, 0);
        waitIdle;
        xfer({`OP_READ, 8'h00, 8'h01, 8'hFE}, 3, 1);
        `CHK("read", 24'hA5_3CFF, {rx[0], rx[1], rx[2]})
        xfer({`OP_FAST, 8'h00, 8'h01, 8'h00, 8'h00}, 1);
        `CHK("page wrap", 8'h5A, rx[0])
        xfer({`OP_WRAP, 8'h00}, 0);
        xfer({`OP_READ, 8'h00, 8'h00, 8'hFF}, 2);
        `CHK("wrap", 16'hFFFF, {rx[0], rx[1]})
        $display("program test done");
    endtask
    task automatic testProtect;
        xfer({`OP_WRITE_UNLOCK_CMD}, 0);
        xfer({`OP_WRSR, 8'h14}, 0);
        waitIdle;
        `CHK("level", 8'h14, rx[2])
        xfer({`OP_WRITE_UNLOCK_CMD}, 0);
        xfer({`OP_PP, 8'h1F, 8'h00, 8'h00, 8'h00}, 0);
        xfer({`OP_CE}, 0);
        waitIdle;
        xfer({`OP_READ, 8'h1F, 8'h00, 8'h00}, 1);
        `CHK("protected", 8'hFF, rx[0])
        xfer({`OP_READ, 8'h00, 8'h01, 8'hFE}, 1);
        `CHK("whole erase", 8'hA5, rx[0])
        xfer({`OP_WRSR, 8'h00}, 0);
        xfer({`OP_WRITE_UNLOCK_CMD}, 0);
        xfer({`OP_SE, 8'h00, 8'h01, 8'h23}, 0);
        waitIdle;
        xfer({`OP_READ, 8'h00, 8'h01, 8'hFE}, 1);
        `CHK("erased", 8'hFF, rx[0])
        $display("erase test done");
    endtask
    task automatic giveVerdict;
        $display("checks %0d mismatches %0d", numChecks, nFail);
        if (nFail == 0 && numChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rst_b = 1;
        repeat (10) @(negedge clk);
        testLatch;
        testProgram;
        testProtect;
        giveVerdict;
    end
    initial begin
        #400us;
        nFail++;
        giveVerdict;
    end
endmodule // serial_multi_io_flash_port_tb_top
bind serial_multi_io_flash_port serial_multi_io_flash_port_asserts i_serial_multi_io_flash_port_asserts (
    .clk(clk), .rst_b(rst_b), .sclk(sclk), .csB(csB), .pauseLane3In(pauseLane3In), .dataLane1Out(dataLane1Out),
    .dataLane1OeB(dataLane1OeB), .pauseLane3OeB(pauseLane3OeB), .memAddr_r(memAddr_r), .memRd_r(memRd_r),
    .memPgm_r(memPgm_r), .memErase_r(memErase_r), .memEraseSize_r(memEraseSize_r));
